// file: test/load_store_address_gen_tb_top.sv
/*
  Self-checking bench for the load/store address generator with a memory model.
  Assumes the design's hand-over timing: take on valid and ready, pulsed writes.
*/
`timescale 1ns/1ps
module load_store_address_gen_tb_top;
  import lsu_pkg::*;
  logic       ref_clk, rst_b, instr_valid, instr_ready, cond_pass, unpriv, subtract;
  mem_op_e    op;
  addr_mode_e mode;
  xfer_size_e size, mem_size;
  word_t      imm_offset, instr_addr, base_value, index_value, store_data1, store_data2;
  word_t      mem_addr, mem_wdata, mem_rdata, rf_wdata, branch_target;
  reg_idx_t   base_register, transfer_register, second_transfer_reg, rf_waddr;
  logic [1:0] left_shift;
  logic [3:0] flags_in, flags_out, mem_delay;
  logic       mem_req, mem_write, mem_unpriv, mem_done, rf_we, branch_valid;
  int         miscompares, check_count;
  reg_idx_t   wa [$];
  word_t      wd [$], bt [$];

  load_store_address_gen dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .op(op), .mode(mode), .size(size), .cond_pass(cond_pass),
    .unpriv(unpriv), .subtract(subtract), .imm_offset(imm_offset), .left_shift(left_shift),
    .instr_addr(instr_addr), .base_value(base_value), .index_value(index_value),
    .store_data1(store_data1), .store_data2(store_data2), .base_register(base_register),
    .transfer_register(transfer_register), .second_transfer_reg(second_transfer_reg),
    .flags_in(flags_in), .mem_addr(mem_addr), .mem_req(mem_req), .mem_write(mem_write),
    .mem_size(mem_size), .mem_unpriv(mem_unpriv), .mem_wdata(mem_wdata), .mem_done(mem_done),
    .mem_rdata(mem_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .branch_valid(branch_valid), .branch_target(branch_target), .flags_out(flags_out));

  lsu_mem_model mem (.ref_clk(ref_clk), .rst_b(rst_b), .delay(mem_delay), .mem_addr(mem_addr),
    .mem_req(mem_req), .mem_write(mem_write), .mem_size(mem_size), .mem_unpriv(mem_unpriv),
    .mem_wdata(mem_wdata), .mem_done(mem_done), .mem_rdata(mem_rdata));

  // 100 ns period clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Bench's own byte-lane pick and widening, little-endian lanes
  function automatic word_t ext(input word_t w, input logic [1:0] ln, input xfer_size_e s);
    logic [7:0]  b;
    logic [15:0] h;
    b = w[{ln, 3'b000} +: 8];
    h = w[{ln[1], 4'h0} +: 16];
    case (s)
      SZ_UBYTE: return {24'h00_0000, b};
      SZ_SBYTE: return {{24{b[7]}}, b};
      SZ_UHALF: return {16'h0000, h};
      SZ_SHALF: return {{16{h[15]}}, h};
      default:  return w;
    endcase
  endfunction : ext

  // Drive the common fields just after an edge
  task automatic setup(input mem_op_e o, input addr_mode_e m, input xfer_size_e s, input logic sb,
                       input word_t imm, input word_t base, input reg_idx_t breg, input reg_idx_t treg);
    @(posedge ref_clk);
    op <= o;
    mode <= m;
    size <= s;
    subtract <= sb;
    imm_offset <= imm;
    base_value <= base;
    base_register <= breg;
    transfer_register <= treg;
  endtask : setup

  // Offer, wait for the take, then collect writes until the sequencer is idle again
  task automatic go();
    int n;
    wa.delete();
    wd.delete();
    bt.delete();
    mem.addr_log.delete();
    mem.data_log.delete();
    mem.attr_log.delete();
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 50);
    // A sequencer that never frees up counts as a failure
    if (instr_ready !== 1'b1) begin
      miscompares++;
      stop_test();
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    for (n = 0; n < 60; n++) begin
      @(negedge ref_clk);
      check(flags_out, flags_in);
      if (rf_we === 1'b1) wa.push_back(rf_waddr);
      if (rf_we === 1'b1) wd.push_back(rf_wdata);
      if (branch_valid === 1'b1) bt.push_back(branch_target);
      if (n >= 2 && instr_ready === 1'b1 && mem_req !== 1'b1) break;
    end
    if (n == 60) begin
      miscompares++;
      stop_test();
    end
  endtask : go

  task automatic t_pc_addr();
    for (int i = 0; i < 3; i++) begin
      setup(OP_PC_ADDR, AM_OFFSET, SZ_WORD, i[0], (i == 2) ? 32'h0 : 32'h0000_0fff, 32'h0, 4'h0, 4'h3);
      instr_addr <= 32'h0000_1002;
      go();
      check(mem.addr_log.size(), 0);
      check(wa[0], 4'h3);
      check(wd[0], (i == 0) ? 32'h0000_2003 : (i == 1) ? 32'h0000_0005 : 32'h0000_1004);
    end
    $display("test pc_addr done");
  endtask : t_pc_addr

  // Every load size from one preset word, offset mode leaves the base alone
  task automatic t_sizes();
    xfer_size_e sz [6] = '{SZ_WORD, SZ_UBYTE, SZ_SBYTE, SZ_UHALF, SZ_SHALF, SZ_SBYTE};
    logic [1:0] ln [6] = '{2'h0, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1};
    mem.store[32'h0000_0200] = 32'h80f1_7f82;
    for (int i = 0; i < 6; i++) begin
      setup(OP_SINGLE_LOAD, AM_OFFSET, sz[i], 1'b0, 32'h0000_0100 + ln[i], 32'h0000_0100, 4'h5, 4'h2);
      go();
      check(mem.addr_log[0], 32'h0000_0200 + ln[i]);
      check(wa.size(), 1);
      check(wd[0], ext(32'h80f1_7f82, ln[i], sz[i]));
    end
    setup(OP_SINGLE_STORE, AM_OFFSET, SZ_WORD, 1'b0, 32'h0, 32'h0000_0340, 4'h5, 4'h2);
    go();
    check(mem.addr_log[0], 32'h0000_0340);
    setup(OP_SINGLE_STORE, AM_OFFSET, SZ_WORD, 1'b0, 32'h0000_0fff, 32'h0000_0001, 4'h5, 4'h2);
    go();
    check(mem.addr_log[0], 32'h0000_1000);
    $display("test sizes done");
  endtask : t_sizes

  task automatic t_indexed();
    mem_delay <= 4'h3;
    setup(OP_SINGLE_LOAD, AM_PRE, SZ_WORD, 1'b1, 32'h0000_00ff, 32'h0000_02ff, 4'h5, 4'h2);
    go();
    check(mem.addr_log[0], 32'h0000_0200);
    check({wa[0], wa[1]}, 8'h25);
    check(wd[1], 32'h0000_0200);
    setup(OP_SINGLE_STORE, AM_POST, SZ_UHALF, 1'b0, 32'h0000_00ff, 32'h0000_0400, 4'h6, 4'h1);
    store_data1 <= 32'h1234_5678;
    go();
    check(mem.addr_log[0], 32'h0000_0400);
    check(mem.attr_log[0], {1'b0, 1'b1, SZ_UHALF});
    check(mem.data_log[0][15:0], 16'h5678);
    check(wa[0], 4'h6);
    check(wd[0], 32'h0000_04ff);
    mem_delay <= 4'h0;
    $display("test indexed done");
  endtask : t_indexed

  task automatic t_regoff();
    for (int s = 0; s < 4; s++) begin
      setup(OP_SINGLE_STORE, AM_REGOFF, SZ_WORD, 1'b0, 32'h0, 32'h0000_1000, 4'h4, 4'h1);
      index_value <= 32'h0000_0010;
      left_shift <= s[1:0];
      go();
      check(mem.addr_log[0], 32'h0000_1000 + (32'h10 << s));
      check(wa.size(), 0);
    end
    $display("test regoff done");
  endtask : t_regoff

  task automatic t_dual();
    mem.store[32'h0000_0a08] = 32'h0bad_f00d;
    mem.store[32'h0000_0a0c] = 32'hc001_cafe;
    setup(OP_DUAL_LOAD, AM_PRE, SZ_WORD, 1'b1, 32'h0000_03fc, 32'h0000_0e04, 4'h3, 4'h8);
    second_transfer_reg <= 4'h9;
    go();
    check(mem.addr_log[1], 32'h0000_0a0c);
    check({wa[0], wa[1], wa[2]}, 12'h893);
    check(wd[1], 32'hc001_cafe);
    check(wd[2], 32'h0000_0a08);
    setup(OP_DUAL_STORE, AM_POST, SZ_WORD, 1'b0, 32'h0000_0004, 32'h0000_0500, 4'h3, 4'h8);
    store_data2 <= 32'h5555_aaaa;
    go();
    check(mem.addr_log[1], 32'h0000_0504);
    check(mem.data_log[1], 32'h5555_aaaa);
    check(wd[0], 32'h0000_0504);
    $display("test dual done");
  endtask : t_dual

  // Branch on a loaded program counter, a failed condition, an unprivileged store
  task automatic t_misc();
    mem.store[32'h0000_0600] = 32'h0000_2345;
    setup(OP_SINGLE_LOAD, AM_OFFSET, SZ_WORD, 1'b0, 32'h0, 32'h0000_0600, 4'h5, 4'hf);
    go();
    check(bt[0], 32'h0000_2344);
    check(wa.size(), 0);
    setup(OP_SINGLE_LOAD, AM_PRE, SZ_WORD, 1'b0, 32'h0000_0010, 32'h0000_0600, 4'h5, 4'h2);
    cond_pass <= 1'b0;
    go();
    check(mem.addr_log.size() + wa.size(), 0);
    setup(OP_SINGLE_STORE, AM_OFFSET, SZ_UBYTE, 1'b0, 32'h0000_0008, 32'h0000_0700, 4'h5, 4'h2);
    cond_pass <= 1'b1;
    unpriv <= 1'b1;
    go();
    check(mem.attr_log[0], {1'b1, 1'b1, SZ_UBYTE});
    unpriv <= 1'b0;
    $display("test misc done");
  endtask : t_misc

  initial begin
    {rst_b, instr_valid, subtract, unpriv, left_shift, mem_delay} = '0;
    {imm_offset, instr_addr, base_value, index_value, store_data1, store_data2} = '0;
    {base_register, transfer_register, second_transfer_reg} = '0;
    op = OP_PC_ADDR;
    mode = AM_OFFSET;
    size = SZ_WORD;
    cond_pass = 1'b1;
    flags_in = 4'ha;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_pc_addr();
    t_sizes();
    t_indexed();
    t_regoff();
    t_dual();
    t_misc();
    stop_test();
  end
endmodule : load_store_address_gen_tb_top

// file: test/lsu_mem_model.sv
/*
  Data memory partner: answers each held request with a one-cycle done pulse
  after a programmable delay, and logs every completed access for the bench.
  Assumes the requester holds mem_req and its fields until done is sampled.
*/
`timescale 1ns/1ps
module lsu_mem_model (
  input  wire logic                ref_clk,    // Core clock
  input  wire logic                rst_b,      // Async reset, active low
  input  wire logic [3:0]          delay,      // Wait cycles before done
  input  wire lsu_pkg::word_t      mem_addr,   // Request address
  input  wire logic                mem_req,    // Request held
  input  wire logic                mem_write,  // Request is a store
  input  wire lsu_pkg::xfer_size_e mem_size,   // Request size
  input  wire logic                mem_unpriv, // Unprivileged access
  input  wire lsu_pkg::word_t      mem_wdata,  // Store data
  output logic                     mem_done,   // Completion pulse
  output lsu_pkg::word_t           mem_rdata   // Read data with done
);
  import lsu_pkg::*;
  word_t      store [word_t]; // Word contents, preset by the bench
  word_t      addr_log [$];   // Completed addresses in order
  word_t      data_log [$];   // Store data or returned data
  logic [4:0] attr_log [$];   // {unpriv, write, size}
  logic [3:0] wait_cnt;
  word_t      last;

  // Unset words read back as the inverted address so stale data never matches
  function automatic word_t fetch(input word_t a);
    word_t k;
    k = {a[31:2], 2'b00};
    return store.exists(k) ? store[k] : ~k;
  endfunction : fetch

  // Done only after the delay; read data outside done is the inverse of the last
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_done <= 1'b0;
      mem_rdata <= 32'hffff_ffff;
      wait_cnt <= 4'h0;
      last <= 32'h0000_0000;
    end else if (mem_req && !mem_done && wait_cnt >= delay) begin
      mem_done <= 1'b1;
      mem_rdata <= fetch(mem_addr);
      last <= fetch(mem_addr);
      wait_cnt <= 4'h0;
      addr_log.push_back(mem_addr);
      data_log.push_back(mem_write ? mem_wdata : fetch(mem_addr));
      attr_log.push_back({mem_unpriv, mem_write, mem_size});
    end else begin
      mem_done <= 1'b0;
      mem_rdata <= ~last;
      wait_cnt <= (mem_req && !mem_done) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : lsu_mem_model

// file: verilog/load_ext_if.sv
/*
  Carrier between the sequencer and the load extender.
  Assumes both ends sit in the core clock domain.
*/
`timescale 1ns/1ps
interface load_ext_if;
  import lsu_pkg::*;
  xfer_size_e size;      // Size and signedness
  logic [1:0] byte_lane; // Low address bits
  word_t      raw;       // Word as read from memory
  word_t      extended;  // Register-ready value

  modport user (output size, output byte_lane, output raw, input extended);
  modport ext  (input size, input byte_lane, input raw, output extended);
endinterface : load_ext_if

// file: verilog/load_extender.sv
/*
  Load data extender: picks the addressed byte or halfword and widens it.
  Assumes little-endian lane order on the data bus.
*/
`timescale 1ns/1ps
module load_extender (
  load_ext_if.ext x  // Extension request and result
);
  import lsu_pkg::*;
  logic [7:0]  byte_sel;
  logic [15:0] half_sel;

  // Lane select, then zero or sign widening to a full word
  always_comb begin
    byte_sel   = x.raw[8*x.byte_lane +: 8];
    half_sel   = x.byte_lane[1] ? x.raw[31:16] : x.raw[15:0];
    x.extended = x.raw;
    case (x.size)
      SZ_UBYTE: x.extended = {24'h00_0000, byte_sel};
      SZ_SBYTE: x.extended = {{24{byte_sel[7]}}, byte_sel};
      SZ_UHALF: x.extended = {16'h0000, half_sel};
      SZ_SHALF: x.extended = {{16{half_sel[15]}}, half_sel};
      default:  x.extended = x.raw;
    endcase
  end
endmodule : load_extender

// file: verilog/load_store_address_gen.sv
/*
  Load/store address generator: PC-relative address, single and dual
  loads/stores with offset, pre-, post-indexed and register-offset modes.
  Assumes the decoder supplies register values and a checked condition,
  and the memory answers each request with mem_done within a few cycles.
*/
`timescale 1ns/1ps
`include "lsu_defines.svh"
module load_store_address_gen (
  input  wire logic               ref_clk,        // Core clock, 10 MHz
  input  wire logic               rst_b,          // Async reset, active low
  input  wire logic               instr_valid,    // Instruction offered
  output logic                    instr_ready,    // Sequencer idle
  input  wire lsu_pkg::mem_op_e   op,             // Operation class
  input  wire lsu_pkg::addr_mode_e mode,          // Addressing mode
  input  wire lsu_pkg::xfer_size_e size,          // Transfer size
  input  wire logic               cond_pass,      // Condition test result
  input  wire logic               unpriv,         // Unprivileged variant
  input  wire logic               subtract,       // Offset subtracted
  input  wire lsu_pkg::word_t     imm_offset,     // Immediate, zero if none
  input  wire logic [1:0]         left_shift,     // Index shift amount
  input  wire lsu_pkg::word_t     instr_addr,     // Current instruction address
  input  wire lsu_pkg::word_t     base_value,     // base_register contents
  input  wire lsu_pkg::word_t     index_value,    // index_register contents
  input  wire lsu_pkg::word_t     store_data1,    // transfer_register contents
  input  wire lsu_pkg::word_t     store_data2,    // second_transfer_reg contents
  input  wire lsu_pkg::reg_idx_t  base_register,  // Base register number
  input  wire lsu_pkg::reg_idx_t  transfer_register,   // First target
  input  wire lsu_pkg::reg_idx_t  second_transfer_reg, // Second target
  input  wire logic [3:0]         flags_in,       // condition_flag_word NZCV
  output lsu_pkg::word_t          mem_addr,       // Memory address
  output logic                    mem_req,        // Memory request held
  output logic                    mem_write,      // Request is a store
  output lsu_pkg::xfer_size_e     mem_size,       // Request size
  output logic                    mem_unpriv,     // Unprivileged access
  output lsu_pkg::word_t          mem_wdata,      // Store data
  input  wire logic               mem_done,       // Request finished
  input  wire lsu_pkg::word_t     mem_rdata,      // Load data with mem_done
  output logic                    rf_we,          // Register write pulse
  output lsu_pkg::reg_idx_t       rf_waddr,       // Register written
  output lsu_pkg::word_t          rf_wdata,       // Value written
  output logic                    branch_valid,   // Branch pulse
  output lsu_pkg::word_t          branch_target,  // Branch address
  output logic [3:0]              flags_out       // Flags held unchanged
);
  import lsu_pkg::*;

  seq_state_e state_reg, state_next;
  word_t      addr_reg, addr_next, wb_reg, wb_next, data2_reg, data2_next;
  logic       req_reg, req_next, write_reg, write_next, unpriv_reg, unpriv_next;
  logic       dual_reg, dual_next, dowb_reg, dowb_next;
  xfer_size_e size_reg, size_next;
  reg_idx_t   tgt1_reg, tgt1_next, tgt2_reg, tgt2_next, bsel_reg, bsel_next;
  word_t      wdata_reg, wdata_next;
  logic       we_reg, we_next, br_reg, br_next;
  reg_idx_t   waddr_reg, waddr_next;
  word_t      rfdata_reg, rfdata_next, brt_reg, brt_next;
  logic [3:0] flags_reg, flags_next;
  logic       ready_reg, ready_next;

  word_t pc_value, offset, sum, ld_value;
  logic  take, dual_op;

  load_ext_if ext_bus ();
  load_extender u_ext (.x(ext_bus));
  assign ext_bus.size      = size_reg;
  assign ext_bus.byte_lane = addr_reg[1:0];
  assign ext_bus.raw       = mem_rdata;
  assign ld_value          = ext_bus.extended;

  // Address arithmetic; wraps modulo 2^32 like the register file
  always_comb begin
    pc_value = (instr_addr + `PC_READ_AHEAD) & ~(32'h1 << `PC_ALIGN_BIT);
    offset   = (mode == AM_REGOFF) ? (index_value << left_shift) : imm_offset;
    if (op == OP_PC_ADDR) begin
      sum = subtract ? pc_value - offset : pc_value + offset;
    end else begin
      sum = subtract ? base_value - offset : base_value + offset;
    end
  end

  assign take    = instr_valid && (state_reg == ST_IDLE);
  assign dual_op = (op == OP_DUAL_LOAD) || (op == OP_DUAL_STORE);

  // Sequencer next-state and outputs
  always_comb begin
    state_next = state_reg;  addr_next = addr_reg;   wb_next = wb_reg;
    data2_next = data2_reg;  req_next = req_reg;     write_next = write_reg;
    unpriv_next = unpriv_reg; dual_next = dual_reg;  dowb_next = dowb_reg;
    size_next = size_reg;    tgt1_next = tgt1_reg;   tgt2_next = tgt2_reg;
    bsel_next = bsel_reg;    wdata_next = wdata_reg;
    we_next = 1'b0;          waddr_next = waddr_reg; rfdata_next = rfdata_reg;
    br_next = 1'b0;          brt_next = brt_reg;
    flags_next = flags_in;   // flags pass through untouched
    case (state_reg)
      ST_IDLE: begin
        if (take && cond_pass) begin // failed condition is dropped whole
          if (op == OP_PC_ADDR) begin
            we_next = 1'b1; // no memory request
            waddr_next = transfer_register;
            rfdata_next = sum;
          end else begin
            addr_next = (mode == AM_POST) ? base_value : sum;
            wb_next = sum;
            dowb_next = (mode == AM_PRE) || (mode == AM_POST);
            write_next = (op == OP_SINGLE_STORE) || (op == OP_DUAL_STORE);
            unpriv_next = unpriv;
            dual_next = dual_op;
            size_next = dual_op ? SZ_WORD : size;
            tgt1_next = transfer_register;
            tgt2_next = second_transfer_reg;
            bsel_next = base_register;
            wdata_next = store_data1;
            data2_next = store_data2;
            req_next = 1'b1;
            state_next = ST_ACCESS;
          end
        end
      end
      ST_ACCESS, ST_SECOND: begin
        if (mem_done) begin
          req_next = 1'b0;
          if (!write_reg) begin
            we_next = (tgt1_reg != `REG_PC);
            waddr_next = tgt1_reg;
            rfdata_next = ld_value;
            if (tgt1_reg == `REG_PC) begin
              br_next = 1'b1;
              brt_next = mem_rdata & ~(32'h1 << `BRANCH_BIT);
            end
          end
          if (state_reg == ST_ACCESS && dual_reg) begin
            addr_next = addr_reg + `DUAL_WORD_STEP;
            wdata_next = data2_reg;
            tgt1_next = tgt2_reg;
            req_next = 1'b1;
            state_next = ST_SECOND;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (dowb_reg) begin
          we_next = 1'b1; // base writeback
          waddr_next = bsel_reg;
          rfdata_next = wb_reg;
        end
        dowb_next = 1'b0;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    // Ready is registered so the output comes straight from a flip-flop
    ready_next = (state_next == ST_IDLE);
  end

  // State registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;    addr_reg <= `ZERO_WORD;  wb_reg <= `ZERO_WORD;
      data2_reg <= `ZERO_WORD; req_reg <= 1'b0;         write_reg <= 1'b0;
      unpriv_reg <= 1'b0;      dual_reg <= 1'b0;        dowb_reg <= 1'b0;
      size_reg <= SZ_WORD;     tgt1_reg <= 4'h0;        tgt2_reg <= 4'h0;
      bsel_reg <= 4'h0;        wdata_reg <= `ZERO_WORD; we_reg <= 1'b0;
      waddr_reg <= 4'h0;       rfdata_reg <= `ZERO_WORD;
      br_reg <= 1'b0;          brt_reg <= `ZERO_WORD;   flags_reg <= `FLAGS_RESET;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next; addr_reg <= addr_next;   wb_reg <= wb_next;
      data2_reg <= data2_next; req_reg <= req_next;     write_reg <= write_next;
      unpriv_reg <= unpriv_next; dual_reg <= dual_next; dowb_reg <= dowb_next;
      size_reg <= size_next;   tgt1_reg <= tgt1_next;   tgt2_reg <= tgt2_next;
      bsel_reg <= bsel_next;   wdata_reg <= wdata_next; we_reg <= we_next;
      waddr_reg <= waddr_next; rfdata_reg <= rfdata_next;
      br_reg <= br_next;       brt_reg <= brt_next;     flags_reg <= flags_next;
      ready_reg <= ready_next;
    end
  end

  // Outputs straight from flip-flops
  assign instr_ready   = ready_reg;
  assign mem_addr      = addr_reg;
  assign mem_req       = req_reg;
  assign mem_write     = write_reg;
  assign mem_size      = size_reg;
  assign mem_unpriv    = unpriv_reg;
  assign mem_wdata     = wdata_reg;
  assign rf_we         = we_reg;
  assign rf_waddr      = waddr_reg;
  assign rf_wdata      = rfdata_reg;
  assign branch_valid  = br_reg;
  assign branch_target = brt_reg;
  assign flags_out     = flags_reg;

  // Sequences for the dual-transfer steps
  sequence s_first_done;
    mem_req && mem_done && (state_reg == ST_ACCESS) && dual_reg;
  endsequence
  sequence s_second_req;
    ##1 mem_req && (mem_addr == $past(mem_addr) + `DUAL_WORD_STEP);
  endsequence

  a_pcaddr_no_access: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && cond_pass && op == OP_PC_ADDR |=> rf_we && !mem_req && rf_wdata == $past(sum))
    else $error("PC-relative address wrong or memory touched");
  a_flags_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> flags_out == $past(flags_in))
    else $error("Flags changed");
  a_fail_no_effect: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && !cond_pass |=> !mem_req && !rf_we && state_reg == ST_IDLE)
    else $error("Failed condition had an effect");
  a_pre_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && cond_pass && op != OP_PC_ADDR && mode == AM_PRE |=> mem_addr == $past(sum) && dowb_reg)
    else $error("Pre-indexed address wrong");
  a_post_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && cond_pass && op != OP_PC_ADDR && mode == AM_POST |=> mem_addr == $past(base_value))
    else $error("Post-indexed address wrong");
  a_offset_no_wb: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && cond_pass && op != OP_PC_ADDR && (mode == AM_OFFSET || mode == AM_REGOFF) |=> !dowb_reg)
    else $error("Offset mode would write base");
  a_dual_second: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_first_done |-> s_second_req)
    else $error("Second word not at address plus four");
  a_pc_branch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mem_req && mem_done && !mem_write && tgt1_reg == `REG_PC |=>
      branch_valid && !rf_we && branch_target == ($past(mem_rdata) & 32'hffff_fffe))
    else $error("PC load branch wrong");
  a_pc_aligned: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && cond_pass && op == OP_PC_ADDR && imm_offset == 32'h0 |=> rf_wdata[1:0] == 2'h0)
    else $error("PC value not word aligned");
endmodule : load_store_address_gen

// file: verilog/lsu_defines.svh
/*
  Constants for the load/store address generator: timing, field positions,
  offset limits and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef LSU_DEFINES_SVH
`define LSU_DEFINES_SVH
`define PC_READ_AHEAD     32'h0000_0004
`define DUAL_WORD_STEP    32'h0000_0004
`define MAX_INDEX_SHIFT   2'h3
`define BRANCH_BIT        0
`define PC_ALIGN_BIT      1
`define REG_SP            4'hd
`define REG_PC            4'hf
`define ZERO_WORD         32'h0000_0000
`define FLAGS_RESET       4'h0
`endif

// file: verilog/lsu_pkg.sv
/*
  Types shared by the load/store address generator and its extender.
  Assumes lsu_defines.svh is on the include path.
*/
package lsu_pkg;
  `include "lsu_defines.svh"

  // Operation class of the instruction handed in
  typedef enum logic [2:0] {
    OP_PC_ADDR     = 3'h0,
    OP_SINGLE_LOAD = 3'h1,
    OP_SINGLE_STORE= 3'h3,
    OP_DUAL_LOAD   = 3'h2,
    OP_DUAL_STORE  = 3'h6
  } mem_op_e;

  // Addressing mode
  typedef enum logic [1:0] {
    AM_OFFSET = 2'h0,
    AM_PRE    = 2'h1,
    AM_POST   = 2'h2,
    AM_REGOFF = 2'h3
  } addr_mode_e;

  // Transfer size and signedness
  typedef enum logic [2:0] {
    SZ_WORD  = 3'h0,
    SZ_UBYTE = 3'h1,
    SZ_SBYTE = 3'h5,
    SZ_UHALF = 3'h2,
    SZ_SHALF = 3'h6
  } xfer_size_e;

  // Sequencer states, Gray coded along IDLE -> ACCESS -> SECOND -> WAIT
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_SECOND = 2'b11,
    ST_WAIT   = 2'b10
  } seq_state_e;

  typedef logic [31:0] word_t;
  typedef logic [3:0]  reg_idx_t;
endpackage : lsu_pkg
